// ==== design/pllcp_pkg.sv ====
// Package: constants, field layout and carrier types for the counter programming port
package pllcp_pkg;

    localparam int CNT_W = 20;
    localparam int FEAT_W = 8;
    localparam int BUS_W = 8;

    // Counter word field positions (MSB first)
    localparam int POS_R5 = 19;
    localparam int POS_R4 = 18;
    localparam int POS_M8 = 17;
    localparam int POS_M7 = 16;
    localparam int POS_PRE = 15;
    localparam int POS_M6 = 14;
    localparam int POS_R3 = 7;
    localparam int POS_A3 = 3;

    // Feature word field positions
    localparam int FPOS_PWDN = 4;
    localparam int FPOS_CLOAD = 3;
    localparam int FPOS_MSELO = 2;
    localparam int FPOS_PREO = 1;
    localparam int FPOS_OUTDIS = 0;

    // Power-up values; the device has no reset of its own
    localparam logic [19:0] CNT_RST = 20'h00000;
    localparam logic [7:0] FEAT_RST = 8'h00;
    localparam logic [7:0] FEAT_RSVD_MASK = 8'hE0;

    typedef enum logic [1:0] {
        PLLCP_MODE_PAR = 2'b00,
        PLLCP_MODE_SER = 2'b01,
        PLLCP_MODE_DIR = 2'b10
    } pllcp_mode_t;

    typedef struct packed {
        logic       pre_bypass;
        logic [6:0] main_low;
        logic [3:0] ref_low;
        logic [3:0] swallow;
    } pllcp_direct_t;

    typedef struct packed {
        logic power_down;
        logic counter_load;
        logic modulus_sel_out;
        logic prescaler_out;
        logic div_out_disable;
    } pllcp_feat_t;

endpackage : pllcp_pkg

// ==== design/pllcp_port.sv ====
// Counter programming port: serial, parallel and direct loading of divider settings
`timescale 1ns/1ps
`default_nettype none
module pllcp_port
(
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  ce_i,
    input  wire logic                  bypass_sel_i,
    input  wire logic                  serial_sel_i,
    input  wire logic                  feature_en_n_i,
    input  wire logic                  serial_clk_i,
    input  wire logic                  serial_data_i,
    input  wire logic                  serial_load_i,
    input  wire logic                  hop_write_i,
    input  wire logic                  feature_write_i,
    input  wire logic [7:0]            pbus_i,
    input  wire logic                  main_high_write_i,
    input  wire logic                  main_low_write_i,
    input  wire logic                  swallow_write_i,
    input  wire logic                  serial_buffer_select_i,
    input  wire logic                  parallel_buffer_select_i,
    input  wire pllcp_pkg::pllcp_direct_t direct_i,
    input  wire logic                  modulus_select_i,
    input  wire logic                  prescaler_raw_i,
    output logic [19:0]                counter_o,
    output var  pllcp_pkg::pllcp_feat_t feature_o,
    output logic                       diag_o,
    output logic                       diag_oe_o
);

    // Two-flop synchronisers for every pin-level input
    localparam int NSYNC = 18;
    logic [NSYNC-1:0] raw_w;
    logic [NSYNC-1:0] s1_reg;
    logic [NSYNC-1:0] s2_reg;
    logic [NSYNC-1:0] s1_next;
    logic [NSYNC-1:0] s2_next;
    logic [NSYNC-1:0] s3_reg;
    logic [NSYNC-1:0] s3_next;

    assign raw_w = {bypass_sel_i, serial_sel_i, feature_en_n_i, serial_clk_i, serial_data_i,
                    serial_load_i, hop_write_i, feature_write_i, main_high_write_i,
                    main_low_write_i, swallow_write_i, serial_buffer_select_i,
                    parallel_buffer_select_i, modulus_select_i, prescaler_raw_i,
                    3'h0};

    always_comb
    begin
        s1_next = raw_w;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (ce_i)
        begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    // Parallel bus is sampled on the same schedule as its strobes
    logic [7:0] b1_reg;
    logic [7:0] b2_reg;
    logic [7:0] b1_next;
    logic [7:0] b2_next;
    pllcp_pkg::pllcp_direct_t d1_reg;
    pllcp_pkg::pllcp_direct_t d2_reg;
    pllcp_pkg::pllcp_direct_t d1_next;
    pllcp_pkg::pllcp_direct_t d2_next;

    always_comb
    begin
        b1_next = pbus_i;
        b2_next = b1_reg;
        d1_next = direct_i;
        d2_next = d1_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (ce_i)
        begin
            b1_reg <= b1_next;
            b2_reg <= b2_next;
            d1_reg <= d1_next;
            d2_reg <= d2_next;
        end
    end

    logic bsel;
    logic ssel;
    logic enh_n;
    logic sdat;
    logic swr;
    logic ewr;
    logic sbuf_sel;
    logic pbuf_sel;
    logic modsel_s;
    logic pre_s;
    logic sclk_rise;
    logic swr_rise;
    logic hop_rise;
    logic ewr_rise;
    logic ewr_fall;
    logic mh_rise;
    logic ml_rise;
    logic sw_rise;

    function automatic logic rise(input logic now, input logic prev);
        rise = now & ~prev;
    endfunction

    assign bsel = s2_reg[17];
    assign ssel = s2_reg[16];
    assign enh_n = s2_reg[15];
    assign sdat = s2_reg[13];
    assign swr = s2_reg[12];
    assign ewr = s2_reg[10];
    assign sbuf_sel = s2_reg[6];
    assign pbuf_sel = s2_reg[5];
    assign modsel_s = s2_reg[4];
    assign pre_s = s2_reg[3];
    assign sclk_rise = rise(s2_reg[14], s3_reg[14]);
    assign swr_rise = rise(s2_reg[12], s3_reg[12]);
    assign hop_rise = rise(s2_reg[11], s3_reg[11]);
    assign ewr_rise = rise(s2_reg[10], s3_reg[10]);
    assign ewr_fall = rise(s3_reg[10], s2_reg[10]);
    assign mh_rise = rise(s2_reg[9], s3_reg[9]);
    assign ml_rise = rise(s2_reg[8], s3_reg[8]);
    assign sw_rise = rise(s2_reg[7], s3_reg[7]);

    pllcp_pkg::pllcp_mode_t mode;
    always_comb
    begin
        if (bsel)
            mode = pllcp_pkg::PLLCP_MODE_DIR;
        else if (ssel)
            mode = pllcp_pkg::PLLCP_MODE_SER;
        else
            mode = pllcp_pkg::PLLCP_MODE_PAR;
    end

    // Programming state
    logic [19:0] prim_reg;
    logic [19:0] prim_next;
    logic [19:0] sec_reg;
    logic [19:0] sec_next;
    logic [7:0]  fshift_reg;
    logic [7:0]  fshift_next;
    logic [7:0]  fhold_reg;
    logic [7:0]  fhold_next;
    logic [19:0] direct_word;
    logic [19:0] counter_next;
    logic [19:0] counter_reg;

    always_comb
    begin
        prim_next = prim_reg;
        sec_next = sec_reg;
        fshift_next = fshift_reg;
        fhold_next = fhold_reg;
        case (mode)
            pllcp_pkg::PLLCP_MODE_SER:
            begin
                if (sclk_rise && !swr && !ewr)
                    prim_next = {prim_reg[18:0], sdat};
                if (sclk_rise && !swr && ewr)
                    fshift_next = {fshift_reg[6:0], sdat};
                if (ewr_fall)
                    fhold_next = fshift_reg;
            end
            pllcp_pkg::PLLCP_MODE_PAR:
            begin
                if (mh_rise)
                    prim_next[pllcp_pkg::POS_R5:pllcp_pkg::POS_M7] = b2_reg[3:0];
                if (ml_rise)
                    prim_next[pllcp_pkg::POS_PRE:pllcp_pkg::POS_R3 + 1] = b2_reg;
                if (sw_rise)
                    prim_next[pllcp_pkg::POS_R3:0] = b2_reg;
                if (ewr_rise)
                    fhold_next = b2_reg;
            end
            default:
            begin
            end
        endcase
        if ((swr_rise || hop_rise) && mode != pllcp_pkg::PLLCP_MODE_DIR)
            sec_next = prim_reg;
    end

    // Direct word: bits 19..16 forced to zero
    assign direct_word = {4'h0, d2_reg};

    always_comb
    begin
        case (mode)
            pllcp_pkg::PLLCP_MODE_SER:
                counter_next = sbuf_sel ? prim_reg : sec_reg;
            pllcp_pkg::PLLCP_MODE_PAR:
                counter_next = pbuf_sel ? prim_reg : sec_reg;
            pllcp_pkg::PLLCP_MODE_DIR:
                counter_next = direct_word;
            default:
                counter_next = direct_word;
        endcase
    end

    // Feature effects, gated by active-low enable; reserved bits never act
    logic [7:0] feat_eff;
    pllcp_pkg::pllcp_feat_t feat_next;
    logic diag_next;
    logic diag_oe_next;
    always_comb
    begin
        feat_eff = enh_n ? 8'h00 : (fhold_reg & ~pllcp_pkg::FEAT_RSVD_MASK);
        feat_next = feat_eff[4:0];
        diag_oe_next = feat_eff[pllcp_pkg::FPOS_MSELO] | feat_eff[pllcp_pkg::FPOS_PREO];
        if (feat_eff[pllcp_pkg::FPOS_MSELO])
            diag_next = modsel_s;
        else if (feat_eff[pllcp_pkg::FPOS_PREO])
            diag_next = pre_s;
        else
            diag_next = 1'b0;
    end

    // resetn_i only sets a known start for simulation; the real part has no reset
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            prim_reg <= pllcp_pkg::CNT_RST;
            sec_reg <= pllcp_pkg::CNT_RST;
            fshift_reg <= pllcp_pkg::FEAT_RST;
            fhold_reg <= pllcp_pkg::FEAT_RST;
            counter_reg <= pllcp_pkg::CNT_RST;
            feature_o <= '0;
            diag_o <= 1'b0;
            diag_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            prim_reg <= prim_next;
            sec_reg <= sec_next;
            fshift_reg <= fshift_next;
            fhold_reg <= fhold_next;
            counter_reg <= counter_next;
            feature_o <= feat_next;
            diag_o <= diag_next;
            diag_oe_o <= diag_oe_next;
        end
    end

    assign counter_o = counter_reg;

    // Assertions
    property p_shift;
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && mode == pllcp_pkg::PLLCP_MODE_SER && sclk_rise && !swr && !ewr)
            |=> prim_reg == {$past(prim_reg[18:0]), $past(sdat)};
    endproperty
    a_shift: assert property (p_shift) else $error("serial shift wrong");

    property p_copy;
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && (swr_rise || hop_rise) && mode != pllcp_pkg::PLLCP_MODE_DIR)
            |=> sec_reg == $past(prim_reg);
    endproperty
    a_copy: assert property (p_copy) else $error("secondary copy missed");
    property p_sel;
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && mode == pllcp_pkg::PLLCP_MODE_SER && !sbuf_sel)
            |=> counter_o == $past(sec_reg);
    endproperty
    a_sel: assert property (p_sel) else $error("buffer select wrong");

    property p_fshift;
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && mode == pllcp_pkg::PLLCP_MODE_SER && sclk_rise && !swr && ewr)
            |=> fshift_reg[0] == $past(sdat) && $stable(prim_reg);
    endproperty
    a_fshift: assert property (p_fshift) else $error("feature shift wrong");

    property p_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && !ewr_fall && !ewr_rise) |=> $stable(fhold_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("feature changed off strobe");
    property p_enh;
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && enh_n) |=> feature_o == '0 && !diag_oe_o;
    endproperty
    a_enh: assert property (p_enh) else $error("feature active while disabled");
    property p_direct;
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && mode == pllcp_pkg::PLLCP_MODE_DIR)
            |=> counter_o[19:16] == 4'h0 && counter_o[15:0] == $past(d2_reg);
    endproperty
    a_direct: assert property (p_direct) else $error("direct word wrong");

    property p_par;
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && mode == pllcp_pkg::PLLCP_MODE_PAR && sw_rise)
            |=> prim_reg[7:0] == $past(b2_reg);
    endproperty
    a_par: assert property (p_par) else $error("swallow section load wrong");

    property p_diag;
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && feat_eff[pllcp_pkg::FPOS_MSELO]) |=> diag_oe_o && diag_o == $past(modsel_s);
    endproperty
    a_diag: assert property (p_diag) else $error("diagnostic routing wrong");

    c_ser: cover property (@(posedge clk_i) disable iff (!resetn_i) ce_i && swr_rise);
    c_par: cover property (@(posedge clk_i) disable iff (!resetn_i) ce_i && ml_rise);
    c_ewr: cover property (@(posedge clk_i) disable iff (!resetn_i) ce_i && ewr_fall);
    c_dir: cover property (@(posedge clk_i) disable iff (!resetn_i)
        mode == pllcp_pkg::PLLCP_MODE_DIR);

endmodule // pllcp_port
`default_nettype wire

// ==== bench/pllcp_host.sv ====
// Host controller model driving the serial, parallel and strapped programming pins
`timescale 1ns/1ps
`default_nettype none
module pllcp_host
(
    input  wire logic                     clk_i,
    output var  logic                     bypass_sel_o,
    output var  logic                     serial_sel_o,
    output var  logic                     serial_clk_o,
    output var  logic                     serial_data_o,
    output var  logic                     serial_load_o,
    output var  logic                     hop_write_o,
    output var  logic                     feature_write_o,
    output var  logic [7:0]               pbus_o,
    output var  logic                     main_high_write_o,
    output var  logic                     main_low_write_o,
    output var  logic                     swallow_write_o,
    output var  pllcp_pkg::pllcp_direct_t direct_o,
    input  wire logic [24:0]              cmd_i,
    output var  logic                     done_o
);
    // 60 ns per level keeps every 30 ns setup, hold and width with margin
    localparam int HOLD = 6;

    initial
    begin
        {bypass_sel_o, serial_sel_o, serial_clk_o, serial_data_o} = 4'h0;
        {serial_load_o, hop_write_o, feature_write_o} = 3'h0;
        {main_high_write_o, main_low_write_o, swallow_write_o} = 3'h0;
        pbus_o = 8'h00;
        direct_o = 16'h0000;
        done_o = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic set_mode(input pllcp_pkg::pllcp_mode_t m);
        bypass_sel_o = m[1];
        serial_sel_o = m[0];
        wt(8);
    endtask

    task automatic set_direct(input pllcp_pkg::pllcp_direct_t v);
        direct_o = v;
        wt(8);
    endtask

    // Serial clock stands low between bits; data flips once its hold is over
    task automatic sbit(input logic b);
        wt(1);
        serial_data_o = b;
        wt(HOLD - 1);
        serial_clk_o = 1'b1;
        wt(HOLD);
        serial_clk_o = 1'b0;
        wt(1);
        serial_data_o = ~b;
    endtask

    task automatic strobe(input int which, input logic v);
        case (which)
            0: serial_load_o = v;
            1: hop_write_o = v;
            2: main_high_write_o = v;
            3: main_low_write_o = v;
            4: swallow_write_o = v;
            default: feature_write_o = v;
        endcase
    endtask

    task automatic pulse(input int which);
        strobe(which, 1'b1);
        wt(HOLD);
        strobe(which, 1'b0);
        wt(HOLD);
    endtask

    task automatic ser_word(input logic [19:0] w, input logic load);
        for (int i = 19; i >= 0; i--)
            sbit(w[i]);
        if (load)
            pulse(0);
    endtask

    // Leaves the feature strobe high so the caller can look before capture
    task automatic feat_shift(input logic [7:0] f);
        strobe(5, 1'b1);
        wt(HOLD);
        for (int i = 7; i >= 0; i--)
            sbit(f[i]);
        wt(HOLD);
    endtask

    task automatic par(input int which, input logic [7:0] d);
        pbus_o = d;
        wt(HOLD);
        pulse(which);
        pbus_o = ~d;
        wt(1);
    endtask

    // One command per rise of the request bit; done_o closes the handshake
    always @(posedge cmd_i[24])
    begin
        case (cmd_i[23:20])
            4'h0: set_mode(pllcp_pkg::pllcp_mode_t'(cmd_i[1:0]));
            4'h1: set_direct(cmd_i[15:0]);
            4'h2: ser_word(cmd_i[19:0], 1'b1);
            4'h3: ser_word(cmd_i[19:0], 1'b0);
            4'h4: pulse(int'(cmd_i[3:0]));
            4'h5: feat_shift(cmd_i[7:0]);
            4'h6: strobe(5, 1'b0);
            default: par(int'(cmd_i[11:8]), cmd_i[7:0]);
        endcase
        done_o = 1'b1;
        wait (!cmd_i[24]);
        done_o = 1'b0;
    end
endmodule // pllcp_host
`default_nettype wire

// ==== bench/test_pllcp_port.sv ====
// Self-checking bench for the counter programming port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_pllcp_port;
    localparam pllcp_pkg::pllcp_mode_t SER = pllcp_pkg::PLLCP_MODE_SER;
    localparam pllcp_pkg::pllcp_mode_t PAR = pllcp_pkg::PLLCP_MODE_PAR;
    localparam pllcp_pkg::pllcp_mode_t DIR = pllcp_pkg::PLLCP_MODE_DIR;
    localparam logic [3:0] H_MODE = 4'h0, H_DIR = 4'h1, H_SER = 4'h2, H_SHIFT = 4'h3;
    localparam logic [3:0] H_PULSE = 4'h4, H_FEAT = 4'h5, H_FDROP = 4'h6, H_PAR = 4'h7;
    typedef struct packed
    {
        pllcp_pkg::pllcp_mode_t mode;
        logic [19:0]            w;
        logic [19:0]            exp;
    } pllcp_row_t;
    pllcp_row_t rows [6] = '{'{SER, 20'hA5C3E, 20'hA5C3E}, '{SER, 20'h5A3C1, 20'h5A3C1},
        '{PAR, 20'hC3F0F, 20'hC3F0F}, '{PAR, 20'h3C0F0, 20'h3C0F0},
        '{DIR, 20'hFABCD, 20'h0ABCD}, '{DIR, 20'h05432, 20'h05432}};
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic fen_n = 1'b0;
    logic sbs = 1'b1;
    logic pbs = 1'b1;
    logic modsel = 1'b0;
    logic praw = 1'b0;
    int   err_count = 0;
    int   n_compared = 0;
    int   cycles = 0;
    logic [24:0] h_cmd = 25'h0000000;
    wire  logic h_done;
    wire  logic bsel, ssel, sclk, sdat, sload, hop, fwr, mhw, mlw, sww, diag_o, diag_oe_o;
    wire  logic [7:0] pbus;
    wire  logic [19:0] counter_o;
    wire  pllcp_pkg::pllcp_direct_t dirp;
    wire  pllcp_pkg::pllcp_feat_t feature_o;

    always #5 clk_i = ~clk_i;

    pllcp_host host (.clk_i(clk_i), .bypass_sel_o(bsel), .serial_sel_o(ssel),
        .serial_clk_o(sclk), .serial_data_o(sdat), .serial_load_o(sload),
        .hop_write_o(hop), .feature_write_o(fwr), .pbus_o(pbus), .main_high_write_o(mhw),
        .main_low_write_o(mlw), .swallow_write_o(sww), .direct_o(dirp), .cmd_i(h_cmd),
        .done_o(h_done));

    pllcp_port uut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .bypass_sel_i(bsel),
        .serial_sel_i(ssel), .feature_en_n_i(fen_n), .serial_clk_i(sclk),
        .serial_data_i(sdat), .serial_load_i(sload), .hop_write_i(hop),
        .feature_write_i(fwr), .pbus_i(pbus), .main_high_write_i(mhw),
        .main_low_write_i(mlw), .swallow_write_i(sww), .serial_buffer_select_i(sbs),
        .parallel_buffer_select_i(pbs), .direct_i(dirp), .modulus_select_i(modsel),
        .prescaler_raw_i(praw), .counter_o(counter_o), .feature_o(feature_o),
        .diag_o(diag_o), .diag_oe_o(diag_oe_o));

    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Hands one command to the host model and waits until it has played out
    task automatic host_do(input logic [3:0] op, input logic [19:0] arg);
        h_cmd = {1'b1, op, arg};
        wait (h_done);
        h_cmd[24] = 1'b0;
        wait (!h_done);
    endtask

    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Ceiling well above the roughly two thousand cycles the sequence needs
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    initial
    begin
        wt(6);
        `CHK("counter_o", 20'h00000, counter_o)
        `CHK("feature_o", 5'h00, feature_o)
        `CHK("diag_oe_o", 1'b0, diag_oe_o)
        resetn_i = 1'b1;
        wt(2);
        foreach (rows[i])
        begin
            host_do(H_MODE, {18'h00000, rows[i].mode});
            case (rows[i].mode)
                SER: host_do(H_SER, rows[i].w);
                PAR:
                begin
                    host_do(H_PAR, {12'h002, 4'h0, rows[i].w[19:16]});
                    host_do(H_PAR, {12'h003, rows[i].w[15:8]});
                    host_do(H_PAR, {12'h004, rows[i].w[7:0]});
                end
                default: host_do(H_DIR, {4'h0, rows[i].w[15:0]});
            endcase
            wt(8);
            `CHK("counter_o", rows[i].exp, counter_o)
        end
        // Strobes in direct mode must leave the strapped word alone
        host_do(H_PAR, 20'h002FF);
        wt(8);
        `CHK("counter_o", 20'h05432, counter_o)
        host_do(H_MODE, {18'h00000, SER});
        host_do(H_SER, 20'h12345);
        host_do(H_SHIFT, 20'hABCDE);
        wt(8);
        `CHK("counter_o", 20'hABCDE, counter_o)
        sbs = 1'b0;
        wt(8);
        `CHK("counter_o", 20'h12345, counter_o)
        host_do(H_PULSE, 20'h00001);
        wt(2);
        `CHK("counter_o", 20'hABCDE, counter_o)
        // A word framed while the clock enable is low must leave no trace
        ce_i = 1'b0;
        host_do(H_SER, 20'h0F0F0);
        `CHK("counter_o", 20'hABCDE, counter_o)
        ce_i = 1'b1;
        sbs = 1'b1;
        wt(8);
        `CHK("counter_o", 20'hABCDE, counter_o)
        host_do(H_FEAT, 20'h00015);
        `CHK("feature_o", 5'h00, feature_o)
        host_do(H_FDROP, 20'h00000);
        wt(8);
        `CHK("feature_o", 5'h15, feature_o)
        fen_n = 1'b1;
        wt(8);
        `CHK("feature_o", 5'h00, feature_o)
        fen_n = 1'b0;
        for (int b = 0; b < 2; b++)
        begin
            modsel = b[0];
            praw = ~b[0];
            wt(8);
            `CHK("diag_o", b[0], diag_o)
            `CHK("diag_oe_o", 1'b1, diag_oe_o)
        end
        host_do(H_MODE, {18'h00000, PAR});
        host_do(H_PAR, 20'h00502);
        wt(8);
        `CHK("feature_o", 5'h02, feature_o)
        for (int b = 0; b < 2; b++)
        begin
            praw = b[0];
            modsel = ~b[0];
            wt(8);
            `CHK("diag_o", b[0], diag_o)
        end
        // Parallel buffer select low shows the copy until a hop strobe
        pbs = 1'b0;
        host_do(H_PAR, 20'h00477);
        wt(8);
        `CHK("counter_o", 20'hABCDE, counter_o)
        host_do(H_PULSE, 20'h00001);
        wt(8);
        `CHK("counter_o", 20'hABC77, counter_o)
        summarize();
    end
endmodule // test_pllcp_port
`default_nettype wire
